/* File: rtl/fes_host.v */
// Host controller that issues flash command sequences and watches erase progress.
// Assumes classic Wishbone software access and a flash wired to the pin ports.
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "fes_consts.vh"
module fes_host #(
  parameter integer WINDOW_CYC  = `FES_WINDOW_CYC,
  parameter integer SUSPEND_CYC = `FES_SUSPEND_CYC
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Flash pins
  output wire [19:0] f_addr_o,
  output wire [7:0]  f_dq_o,
  output wire        f_dq_oe_o,
  input  wire [7:0]  f_dq_i,
  output wire        f_ce_n_o,
  output wire        f_we_n_o,
  output wire        f_oe_n_o,
  output reg         f_reset_n_o,
  input  wire        ready_busy_n_i
);

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_ISSUE = 3'd1;
  localparam [2:0] ST_WAIT  = 3'd2;
  localparam [2:0] ST_EXTRA = 3'd3;
  localparam [2:0] ST_ERASE = 3'd4;
  localparam [2:0] ST_SUSP  = 3'd5;

  reg  [2:0]  state_r;
  reg  [3:0]  op_r;
  reg  [2:0]  step_r;
  reg  [2:0]  nsteps_r;
  reg  [19:0] addr_r;
  reg  [7:0]  data_r;
  reg  [15:0] sectors_r;
  reg  [15:0] pend_r;
  reg  [3:0]  sec_idx_r;
  reg  [15:0] timer_r;
  reg         hw_reset_r;
  reg         busy_err_r;
  reg         window_open_r;
  reg         erasing_r;
  reg         chip_erase_r;
  reg         suspended_r;
  reg         go_r;
  reg  [19:0] cyc_addr;
  reg  [7:0]  cyc_data;
  reg         cyc_write;
  reg         rb_s1_r;
  reg         rb_s2_r;
  wire        cyc_busy;
  wire        cyc_done;
  wire [7:0]  cyc_rdata;
  wire        wb_req;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always @(posedge clk_i) begin
    rb_s1_r <= ready_busy_n_i;
    rb_s2_r <= rb_s1_r;
  end

  // Builds the address and data of each write of the chosen sequence.
  always @* begin
    cyc_addr  = `FES_ADDR_UNLOCK1;
    cyc_data  = `FES_DATA_UNLOCK1;
    cyc_write = 1'b1;
    case (op_r)
      `FES_OP_READ: begin
        cyc_addr  = addr_r;
        cyc_write = 1'b0;
      end
      `FES_OP_RESET: cyc_data = `FES_CMD_RESET;
      `FES_OP_SUSPEND: cyc_data = `FES_CMD_SUSPEND;
      `FES_OP_RESUME: cyc_data = `FES_CMD_RESUME;
      default: begin
        // Unlock writes carry only the low address bits.
        case (step_r)
          3'd0: cyc_data = `FES_DATA_UNLOCK1;
          3'd1: begin
            cyc_addr = `FES_ADDR_UNLOCK2;
            cyc_data = `FES_DATA_UNLOCK2;
          end
          3'd2: begin
            if (op_r == `FES_OP_PROGRAM) begin
              cyc_data = `FES_CMD_PROGRAM;
            end else if (op_r == `FES_OP_IDENT) begin
              cyc_data = `FES_CMD_IDENT;
            end else begin
              cyc_data = `FES_CMD_ERASE_SET;
            end
          end
          3'd3: begin
            if (op_r == `FES_OP_PROGRAM) begin
              cyc_addr = addr_r;
              cyc_data = data_r;
            end else begin
              cyc_data = `FES_DATA_UNLOCK1;
            end
          end
          3'd4: begin
            cyc_addr = `FES_ADDR_UNLOCK2;
            cyc_data = `FES_DATA_UNLOCK2;
          end
          default: begin
            if (op_r == `FES_OP_CHIP) begin
              cyc_data = `FES_CMD_CHIP;
            end else begin
              cyc_addr = {sec_idx_r, 16'h0000};
              cyc_data = `FES_CMD_SECTOR;
            end
          end
        endcase
      end
    endcase
  end

  fes_bus_cycle u_cycle (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .start_i   (go_r),
    .write_i   (cyc_write),
    .addr_i    (cyc_addr),
    .data_i    (cyc_data),
    .busy_o    (cyc_busy),
    .done_o    (cyc_done),
    .rdata_o   (cyc_rdata),
    .f_addr_o  (f_addr_o),
    .f_dq_o    (f_dq_o),
    .f_dq_oe_o (f_dq_oe_o),
    .f_dq_i    (f_dq_i),
    .f_ce_n_o  (f_ce_n_o),
    .f_we_n_o  (f_we_n_o),
    .f_oe_n_o  (f_oe_n_o)
  );

  // Lowest pending sector, used for the next selection write.
  function [3:0] first_set;
    input [15:0] v;
    integer k;
    begin
      first_set = 4'h0;
      for (k = 15; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_set = k[3:0];
        end
      end
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r       <= ST_IDLE;
      op_r          <= `FES_OP_NONE;
      step_r        <= 3'd0;
      nsteps_r      <= 3'd0;
      addr_r        <= 20'h00000;
      data_r        <= 8'h00;
      sectors_r     <= 16'h0000;
      pend_r        <= 16'h0000;
      sec_idx_r     <= 4'h0;
      timer_r       <= 16'h0000;
      hw_reset_r    <= 1'b0;
      busy_err_r    <= 1'b0;
      window_open_r <= 1'b0;
      erasing_r     <= 1'b0;
      chip_erase_r  <= 1'b0;
      suspended_r   <= 1'b0;
      go_r          <= 1'b0;
      f_reset_n_o   <= 1'b1;
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h00000000;
    end else begin
      go_r     <= 1'b0;
      wb_ack_o <= wb_req;
      f_reset_n_o <= ~hw_reset_r;
      if (timer_r != 16'h0000) begin
        timer_r <= timer_r - 16'h0001;
      end
      if (wb_req) begin
        wb_dat_o <= 32'h00000000;
        if (wb_we_i) begin
          case ({24'h000000, wb_adr_i})
            `FES_REG_CTRL: begin
              if (wb_sel_i[0]) begin
                hw_reset_r <= wb_dat_i[4];
                busy_err_r <= 1'b0;
                // Suspend is sent only while a sector erase runs or its selection window is open.
                if (wb_dat_i[3:0] == `FES_OP_SUSPEND &&
                    !((erasing_r && !chip_erase_r) || window_open_r)) begin
                  busy_err_r <= 1'b1;
                end else if (wb_dat_i[3:0] == `FES_OP_RESUME && !suspended_r) begin
                  busy_err_r <= 1'b1;
                end else if (wb_dat_i[3:0] != `FES_OP_NONE && state_r == ST_IDLE) begin
                  op_r     <= wb_dat_i[3:0];
                  step_r   <= 3'd0;
                  nsteps_r <= (wb_dat_i[3:0] == `FES_OP_PROGRAM) ? 3'd3 :
                              (wb_dat_i[3:0] == `FES_OP_IDENT) ? 3'd2 :
                              (wb_dat_i[3:0] == `FES_OP_CHIP ||
                               wb_dat_i[3:0] == `FES_OP_SECTOR) ? 3'd5 : 3'd0;
                  pend_r    <= sectors_r;
                  sec_idx_r <= first_set(sectors_r);
                  state_r   <= ST_ISSUE;
                end else if (wb_dat_i[3:0] != `FES_OP_NONE) begin
                  busy_err_r <= 1'b1;
                end
              end
            end
            `FES_REG_ADDR: addr_r <= wb_dat_i[19:0];
            `FES_REG_DATA: if (wb_sel_i[0]) data_r <= wb_dat_i[7:0];
            `FES_REG_SECTORS: sectors_r <= wb_dat_i[15:0];
            default: ;
          endcase
        end else begin
          case ({24'h000000, wb_adr_i})
            `FES_REG_CTRL:    wb_dat_o <= {27'h0000000, hw_reset_r, op_r};
            `FES_REG_ADDR:    wb_dat_o <= {12'h000, addr_r};
            `FES_REG_DATA:    wb_dat_o <= {24'h000000, data_r};
            `FES_REG_STATUS:  wb_dat_o <= {26'h0000000, busy_err_r, ~rb_s2_r,
                                           suspended_r && (timer_r == 16'h0000),
                                           erasing_r, window_open_r, state_r != ST_IDLE};
            `FES_REG_SECTORS: wb_dat_o <= {16'h0000, sectors_r};
            `FES_REG_RDATA:   wb_dat_o <= {24'h000000, cyc_rdata};
            default:          wb_dat_o <= 32'h00000000;
          endcase
        end
      end
      case (state_r)
        ST_IDLE: begin
          // Ready again means the erase finished and the part reads array.
          if (erasing_r && timer_r == 16'h0000 && rb_s2_r) begin
            erasing_r    <= 1'b0;
            chip_erase_r <= 1'b0;
          end
          // The window closes by itself; then the part erases.
          if (window_open_r && timer_r == 16'h0000) begin
            window_open_r <= 1'b0;
            erasing_r     <= 1'b1;
            timer_r       <= 16'h0004;
          end
        end
        ST_ISSUE: begin
          if (!cyc_busy && !go_r) begin
            go_r    <= 1'b1;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cyc_done) begin
            if (step_r < nsteps_r) begin
              step_r  <= step_r + 3'd1;
              state_r <= ST_ISSUE;
            end else begin
              state_r <= ST_IDLE;
              case (op_r)
                `FES_OP_SECTOR: begin
                  pend_r    <= pend_r & ~(16'h0001 << sec_idx_r);
                  window_open_r <= 1'b1;
                  timer_r   <= WINDOW_CYC[15:0];
                  state_r   <= ST_EXTRA;
                end
                `FES_OP_CHIP: begin
                  erasing_r    <= 1'b1;
                  chip_erase_r <= 1'b1;
                  timer_r   <= 16'h0004;
                end
                `FES_OP_SUSPEND: begin
                  // Suspended is reported after the worst-case latency, or at once if the window was still open.
                  window_open_r <= 1'b0;
                  erasing_r     <= 1'b0;
                  suspended_r   <= 1'b1;
                  timer_r       <= window_open_r ? 16'h0000 : SUSPEND_CYC[15:0];
                end
                `FES_OP_RESUME: begin
                  suspended_r <= 1'b0;
                  erasing_r   <= 1'b1;
                  timer_r     <= 16'h0004;
                end
                `FES_OP_RESET: window_open_r <= 1'b0;
                default: ;
              endcase
            end
          end
        end
        ST_EXTRA: begin
          // Remaining selections follow back to back, well inside the window.
          if (pend_r == 16'h0000) begin
            state_r <= ST_IDLE;
          end else if (!cyc_busy && !go_r) begin
            sec_idx_r <= first_set(pend_r);
            step_r    <= 3'd5;
            state_r   <= ST_ISSUE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // Placed last so a hardware reset of the part wins over updates of the state and the erase, window and suspend flags in the same cycle.
      if (hw_reset_r) begin
        state_r       <= ST_IDLE;
        window_open_r <= 1'b0;
        erasing_r     <= 1'b0;
        chip_erase_r  <= 1'b0;
        suspended_r   <= 1'b0;
      end
    end
  end

endmodule // fes_host

/* File: rtl/fes_consts.vh */
// Constants for the flash erase command sequencer host controller.
// Assumes a byte-wide parallel flash on asynchronous strobes and a 10 MHz system clock.
`ifndef FES_CONSTS_VH
`define FES_CONSTS_VH

`define FES_ADDR_UNLOCK1   20'h00555
`define FES_ADDR_UNLOCK2   20'h002aa
`define FES_DATA_UNLOCK1   8'haa
`define FES_DATA_UNLOCK2   8'h55
`define FES_CMD_ERASE_SET  8'h80
`define FES_CMD_CHIP       8'h10
`define FES_CMD_SECTOR     8'h30
`define FES_CMD_PROGRAM    8'ha0
`define FES_CMD_IDENT      8'h90
`define FES_CMD_RESET      8'hf0
`define FES_CMD_SUSPEND    8'hb0
`define FES_CMD_RESUME     8'h30

`define FES_SECTOR_LSB     16

`define FES_REG_CTRL       32'h00000000
`define FES_REG_ADDR       32'h00000004
`define FES_REG_DATA       32'h00000008
`define FES_REG_STATUS     32'h0000000c
`define FES_REG_SECTORS    32'h00000010
`define FES_REG_RDATA      32'h00000014

`define FES_OP_NONE        4'h0
`define FES_OP_READ        4'h1
`define FES_OP_RESET       4'h2
`define FES_OP_PROGRAM     4'h3
`define FES_OP_CHIP        4'h4
`define FES_OP_SECTOR      4'h5
`define FES_OP_SUSPEND     4'h6
`define FES_OP_RESUME      4'h7
`define FES_OP_IDENT       4'h8

`define FES_CLK_HZ         10000000
`define FES_WINDOW_US      50
`define FES_SUSPEND_US     20
`define FES_STROBE_NS      200
`define FES_SETUP_NS       100
`define FES_WINDOW_CYC     ((`FES_WINDOW_US * (`FES_CLK_HZ / 1000000)))
`define FES_SUSPEND_CYC    ((`FES_SUSPEND_US * (`FES_CLK_HZ / 1000000)))
`define FES_STROBE_CYC     ((`FES_STROBE_NS * (`FES_CLK_HZ / 1000000) + 999) / 1000)
`define FES_SETUP_CYC      ((`FES_SETUP_NS * (`FES_CLK_HZ / 1000000) + 999) / 1000)

`endif

/* File: rtl/fes_bus_cycle.v */
// One asynchronous write or read cycle on the flash pins.
// Assumes the flash pins are wired straight to the part; read data is synchronised here.
`timescale 1ns/1ps
`include "fes_consts.vh"
module fes_bus_cycle #(
  parameter integer SETUP_CYC  = `FES_SETUP_CYC,
  parameter integer STROBE_CYC = `FES_STROBE_CYC
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Request
  input  wire        start_i,
  input  wire        write_i,
  input  wire [19:0] addr_i,
  input  wire [7:0]  data_i,
  output wire        busy_o,
  output reg         done_o,
  output reg  [7:0]  rdata_o,
  // Flash pins
  output reg  [19:0] f_addr_o,
  output reg  [7:0]  f_dq_o,
  output reg         f_dq_oe_o,
  input  wire [7:0]  f_dq_i,
  output reg         f_ce_n_o,
  output reg         f_we_n_o,
  output reg         f_oe_n_o
);

  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_SETUP = 2'd1;
  localparam [1:0] ST_PULSE = 2'd2;
  localparam [1:0] ST_HOLD  = 2'd3;

  reg [1:0] state_r;
  reg [7:0] cnt_r;
  reg       wr_r;
  reg [7:0] dq_s1_r;
  reg [7:0] dq_s2_r;

  assign busy_o = (state_r != ST_IDLE);

  always @(posedge clk_i) begin
    dq_s1_r <= f_dq_i;
    dq_s2_r <= dq_s1_r;
  end

  // Address settles before the strobe falls and data before it rises.
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r   <= ST_IDLE;
      cnt_r     <= 8'h00;
      wr_r      <= 1'b0;
      done_o    <= 1'b0;
      rdata_o   <= 8'h00;
      f_addr_o  <= 20'h00000;
      f_dq_o    <= 8'h00;
      f_dq_oe_o <= 1'b0;
      f_ce_n_o  <= 1'b1;
      f_we_n_o  <= 1'b1;
      f_oe_n_o  <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_i) begin
            f_addr_o  <= addr_i;
            f_dq_o    <= data_i;
            f_dq_oe_o <= write_i;
            wr_r      <= write_i;
            f_ce_n_o  <= 1'b0;
            cnt_r     <= SETUP_CYC[7:0];
            state_r   <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            f_we_n_o <= ~wr_r;
            f_oe_n_o <= wr_r;
            cnt_r    <= STROBE_CYC[7:0] + 8'h02;
            state_r  <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            rdata_o  <= dq_s2_r;
            f_we_n_o <= 1'b1;
            f_oe_n_o <= 1'b1;
            state_r  <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          f_ce_n_o  <= 1'b1;
          f_dq_oe_o <= 1'b0;
          done_o    <= 1'b1;
          state_r   <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // fes_bus_cycle

/* File: dv/fes_host_sva.sv */
// Concurrent checks on the flash host controller's Wishbone and flash pin ports.
// Assumes it is bound to fes_host and that every port runs on clk_i.
`timescale 1ns/1ps
module fes_host_sva #(
  parameter integer WINDOW_CYC  = 500,
  parameter integer SUSPEND_CYC = 200
) (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Wishbone
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  // Flash pins
  input wire [19:0] f_addr_o,
  input wire [7:0]  f_dq_o,
  input wire        f_dq_oe_o,
  input wire        f_ce_n_o,
  input wire        f_we_n_o,
  input wire        f_oe_n_o,
  input wire        f_reset_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("Request not acknowledged");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Acknowledge longer than one cycle");
  property p_we_drive; !f_we_n_o |-> !f_ce_n_o && f_oe_n_o && f_dq_oe_o; endproperty
  a_we_drive: assert property (p_we_drive) else $error("Write strobe without drive");
  property p_oe_float; !f_oe_n_o |-> !f_dq_oe_o && !f_ce_n_o; endproperty
  a_oe_float: assert property (p_oe_float) else $error("Read strobe while driving");
  property p_we_hold;
    !f_we_n_o && $past(!f_we_n_o) |-> $stable(f_addr_o) && $stable(f_dq_o);
  endproperty
  a_we_hold: assert property (p_we_hold) else $error("Address or data moved in write");
  property p_we_width; $fell(f_we_n_o) |-> (!f_we_n_o)[*4] ##1 f_we_n_o; endproperty
  a_we_width: assert property (p_we_width) else $error("Write strobe width wrong");
  property p_oe_width; $fell(f_oe_n_o) |-> (!f_oe_n_o)[*4] ##1 f_oe_n_o; endproperty
  a_oe_width: assert property (p_oe_width) else $error("Read strobe width wrong");
  property p_ce_lead; $fell(f_we_n_o) |-> $past(!f_ce_n_o); endproperty
  a_ce_lead: assert property (p_ce_lead) else $error("Chip enable not ahead of strobe");
  property p_hw_quiet; !f_reset_n_o |-> f_we_n_o; endproperty
  a_hw_quiet: assert property (p_hw_quiet) else $error("Write during hardware reset");
  c_write: cover property ($fell(f_we_n_o));
  c_read: cover property ($fell(f_oe_n_o));
  c_hwrst: cover property ($fell(f_reset_n_o));
endmodule // fes_host_sva
bind fes_host fes_host_sva #(.WINDOW_CYC(WINDOW_CYC), .SUSPEND_CYC(SUSPEND_CYC)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .f_addr_o(f_addr_o), .f_dq_o(f_dq_o), .f_dq_oe_o(f_dq_oe_o),
  .f_ce_n_o(f_ce_n_o), .f_we_n_o(f_we_n_o), .f_oe_n_o(f_oe_n_o), .f_reset_n_o(f_reset_n_o));

/* File: dv/fes_flash_model.sv */
// Behavioural byte-wide flash: decodes command writes and logs every write made outside hardware reset.
// Assumes clk_i paces the self-timed window and erase timers and samples the reset pin.
`timescale 1ns/1ps
module fes_flash_model #(
  parameter integer WIN = 500,
  parameter integer ERS = 300
) (
  // Timer clock
  input  wire        clk_i,
  // Bus pins
  input  wire [19:0] addr_i,
  input  wire [7:0]  dq_i,
  input  wire        ce_n_i,
  input  wire        we_n_i,
  input  wire        oe_n_i,
  input  wire        reset_n_i,
  output wire [7:0]  dq_o,
  output wire        ready_busy_n_o
);
  localparam integer RD = 0, ID = 1, WN = 2, ER = 3, SU = 4, BZ = 5;
  integer      mode = RD, s = 0, t = 0, nw = 0;
  logic [19:0] la = 20'h00000, wa [0:63];
  logic [7:0]  wd [0:63], lastq = 8'h00;
  logic [15:0] sel = 16'h0000;
  logic        idsu = 1'b0;
  wire         u1 = la[10:0] == 11'h555;
  wire         u2 = la[10:0] == 11'h2aa;
  // Identification reads give one code at any address; the value is arbitrary.
  wire [7:0]   rd = (mode == ID) ? 8'hc3 :
                    (mode == SU && sel[addr_i[19:16]]) ? 8'h80 : addr_i[7:0] ^ 8'h5a;
  // A released bus shows the inverse of the last value so a stale read cannot match.
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~lastq;
  assign ready_busy_n_o = !(mode == WN || mode == ER || mode == BZ);
  always @(posedge oe_n_i) lastq <= rd;
  always @(negedge we_n_i) la <= addr_i;
  always @(posedge we_n_i) if (!ce_n_i && reset_n_i) begin
    wa[nw] = la;
    wd[nw] = dq_i;
    nw = nw + 1;
    if (mode == WN && dq_i == 8'h30) begin
      sel[la[19:16]] = 1'b1;
      t = 0;
    end else if ((mode == WN || mode == ER) && dq_i == 8'hb0) mode = SU;
    else if (mode == SU && dq_i == 8'h30) mode = ER;
    else if (mode == WN) mode = RD;
    else if (mode == RD || mode == ID || mode == SU) begin
      if (dq_i == 8'hf0) begin
        s = 0;
        if (mode == ID) mode = idsu ? SU : RD;
      end else case (s)
        0: s = (u1 && dq_i == 8'haa) ? 1 : 0;
        1: s = (u2 && dq_i == 8'h55) ? 2 : 0;
        2: begin
          s = !u1 ? 0 : dq_i == 8'h80 ? 3 : dq_i == 8'ha0 ? 6 : 0;
          if (u1 && dq_i == 8'h90 && (mode == RD || mode == SU)) begin
            idsu = (mode == SU);
            mode = ID;
          end
        end
        3: s = (u1 && dq_i == 8'haa) ? 4 : 0;
        4: s = (u2 && dq_i == 8'h55) ? 5 : 0;
        5: begin
          s = 0;
          t = 0;
          if (dq_i == 8'h30 && mode != SU) begin
            sel = 16'h0001 << la[19:16];
            mode = WN;
          end
          if (dq_i == 8'h10 && u1 && mode != SU) mode = BZ;
        end
        default: begin
          s = 0;
          t = ERS - 20;
          if (mode != SU) mode = BZ;
        end
      endcase
    end
  end
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode = RD;
      s = 0;
    end else if (mode == WN || mode == ER || mode == BZ) begin
      t = t + 1;
      if (mode == WN && t >= WIN) begin
        mode = ER;
        t = 0;
      end else if (mode != WN && t >= ERS) begin
        mode = RD;
        sel = 16'h0000;
      end
    end
  end
endmodule // fes_flash_model

/* File: dv/tb_top.sv */
// Self-checking bench: Wishbone accesses to the host controller, flash write log checks.
// Assumes the behavioural flash model stands on the pins.
`timescale 1ns/1ps
module tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, q;
  logic [19:0] ua [0:4] = '{20'h555, 20'h2aa, 20'h555, 20'h555, 20'h2aa};
  logic [7:0]  ud [0:4] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55};
  wire  [31:0] dat_o;
  wire  [19:0] fa;
  wire  [7:0]  fdo, fdi;
  wire         ack, foe, ce_n, we_n, oe_n, rst_n, rb_n;
  integer      n_errors = 0, checked = 0, b;
  fes_host DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .f_addr_o(fa), .f_dq_o(fdo), .f_dq_oe_o(foe), .f_dq_i(fdi), .f_ce_n_o(ce_n),
    .f_we_n_o(we_n), .f_oe_n_o(oe_n), .f_reset_n_o(rst_n), .ready_busy_n_i(rb_n));
  fes_flash_model FL (.clk_i(clk_i), .addr_i(fa), .dq_i(fdo), .ce_n_i(ce_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .reset_n_i(rst_n), .dq_o(fdi), .ready_busy_n_o(rb_n));
  initial forever #50 clk_i = ~clk_i;
  task automatic finish_test;
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0); ck(q, e);
  endtask
  task automatic op(input logic [31:0] c); wb(1'b1, 8'h00, c); endtask
  // Polls status until the chosen bit reads the wanted level; the watchdog bounds it.
  task automatic wst(input integer n, input logic v);
    do wb(1'b0, 8'h0c, 32'h0); while (q[n] !== v);
  endtask
  task automatic idle; do wb(1'b0, 8'h0c, 32'h0); while (q[4:0] !== 5'h00); endtask
  task automatic fw(input integer i, input logic [19:0] m, a, input logic [7:0] d);
    ck({FL.wa[i] & m, FL.wd[i]}, {a, d});
  endtask
  task automatic head(input integer i);
    for (int k = 0; k < 5; k++) fw(i + k, 20'h007ff, ua[k], ud[k]);
  endtask
  initial begin
    #6000000;
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h0c, 32'h0);
    rd(8'h20, 32'h0);
    wb(1'b1, 8'h04, 32'h00001234); op(32'h1); idle;
    rd(8'h14, 32'h6e);
    wb(1'b1, 8'h04, 32'h0005a321); wb(1'b1, 8'h08, 32'h3c); b = FL.nw; op(32'h3); idle;
    ck(FL.nw - b, 4);
    for (int k = 0; k < 3; k++) fw(b + k, 20'h007ff, ua[k], (k == 2) ? 8'ha0 : ud[k]);
    fw(b + 3, 20'hfffff, 20'h5a321, 8'h3c);
    wb(1'b1, 8'h10, 32'h8002); b = FL.nw; op(32'h5); wst(1, 1'b1);
    ck(q[2:1], 2'b01);
    wst(2, 1'b1);
    head(b);
    fw(b + 5, 20'hf0000, 20'h10000, 8'h30);
    fw(b + 6, 20'hf0000, 20'hf0000, 8'h30);
    op(32'h6); wst(3, 1'b1);
    fw(FL.nw - 1, 20'h0, 20'h0, 8'hb0);
    wb(1'b1, 8'h04, 32'h0001fff0); op(32'h1); wst(0, 1'b0);
    rd(8'h14, 32'h80);
    wb(1'b1, 8'h04, 32'h00020011); op(32'h1); wst(0, 1'b0);
    rd(8'h14, 32'h4b);
    b = FL.nw; op(32'h8); wst(0, 1'b0);
    ck(FL.nw - b, 3);
    for (int k = 0; k < 3; k++) fw(b + k, 20'h007ff, ua[k], (k == 2) ? 8'h90 : ud[k]);
    wb(1'b1, 8'h04, 32'h0001fff0); op(32'h1); wst(0, 1'b0);
    rd(8'h14, 32'hc3);
    b = FL.nw; op(32'h2); wst(0, 1'b0);
    fw(b, 20'h0, 20'h0, 8'hf0);
    ck(FL.mode, 4);
    ck(q[3], 1);
    b = FL.nw; op(32'h7); wst(3, 1'b0);
    fw(b, 20'h0, 20'h0, 8'h30);
    idle;
    b = FL.nw; op(32'h7); wst(0, 1'b0);
    ck(FL.nw - b, 0);
    ck(q[5], 1);
    b = FL.nw; op(32'h4); wst(4, 1'b1);
    head(b);
    fw(b + 5, 20'h007ff, 20'h555, 8'h10);
    b = FL.nw; op(32'h6); wst(0, 1'b0);
    ck(FL.nw - b, 0);
    ck(q[5], 1);
    idle;
    wb(1'b1, 8'h10, 32'h1); op(32'h5); wst(2, 1'b1);
    op(32'h10); op(32'h0); idle;
    ck(FL.mode, 0);
    b = FL.nw; op(32'h2); wst(0, 1'b0);
    fw(b, 20'h0, 20'h0, 8'hf0);
    finish_test;
  end
endmodule // tb_top
